//--- core/cbt_pkg.sv
// shared constants, types and helpers for the can buffer flag tracking block
package cbt_pkg;
   localparam int NBUF = 32;
   localparam int IDW = 11;
   localparam int IRQW = 3;
   // register byte offsets
   localparam logic [7:0] OFS_CFG = 8'hC0;
   localparam logic [7:0] OFS_FRESH = 8'h98;
   localparam logic [7:0] OFS_PEND = 8'hCC;
   localparam logic [7:0] OFS_ADD = 8'hD0;
   localparam logic [7:0] OFS_CANCEL = 8'hD4;
   localparam logic [7:0] OFS_OCC = 8'hD8;
   localparam logic [7:0] OFS_CFIN = 8'hDC;
   localparam logic [7:0] OFS_IDWR = 8'hE0;
   localparam logic [7:0] OFS_IST = 8'hE4;
   localparam logic [7:0] OFS_IMSK = 8'hE8;
   localparam logic [7:0] ADDR_ALIGN = 8'hFC;
   // reset values
   localparam logic [31:0] RST_REG = 32'h0000_0000;
   localparam logic [IRQW-1:0] RST_IRQ = 3'h0;
   // field positions
   localparam int IDWR_ID_LSB = 0;
   localparam int IDWR_IDX_LSB = 16;
   localparam int IRQ_RX = 0;
   localparam int IRQ_OCC = 1;
   localparam int IRQ_CFIN = 2;
   // bus answers and last scan count
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [5:0] SCAN_LAST = 6'h20;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } cbt_wr_t;

   typedef enum {SC_IDLE, SC_RUN, SC_PICK} cbt_scan_t;

   // one bit set at a buffer position
   function automatic logic [NBUF-1:0] cbt_onehot(input logic [4:0] idx);
      cbt_onehot = {{(NBUF-1){1'b0}}, 1'b1} << idx;
   endfunction : cbt_onehot

   // byte enables widened to a bit mask
   function automatic logic [31:0] cbt_strb_mask(input logic [3:0] strb);
      cbt_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : cbt_strb_mask
endpackage : cbt_pkg

//--- core/cbt_id_mem.sv
// message identifier store, one word per transmit buffer, registered read
`timescale 1ns/1ps
module cbt_id_mem import cbt_pkg::*; (
   input wire logic aclk,
   input wire logic ce,
   input wire logic we,
   input wire logic [4:0] waddr,
   input wire logic [IDW-1:0] wdata,
   input wire logic [4:0] raddr,
   output logic [IDW-1:0] rdata
);
   logic [IDW-1:0] mem [NBUF];

   // write port and registered read port
   always_ff @(posedge aclk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule : cbt_id_mem

//--- core/cbt_axil_slave.sv
// axi4-lite slave front end: captures accesses, answers from registers
`timescale 1ns/1ps
module cbt_axil_slave import cbt_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_go,
   output cbt_wr_t wr,
   input wire logic wr_err,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_got, w_got, rd_pend;
   logic next_aw_got, next_w_got, next_rd_pend;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   cbt_wr_t next_wr;
   logic [7:0] next_rd_addr;

   assign wr_go = aw_got && w_got && !s_axi_bvalid;

   // handshake bookkeeping for both directions
   always_comb begin
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_wr = wr;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rd_pend = rd_pend;
      next_rd_addr = rd_addr;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_got = 1'b1;
         next_wr.addr = s_axi_awaddr & ADDR_ALIGN;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_got = 1'b1;
         next_wr.data = s_axi_wdata;
         next_wr.strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_go) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rd_pend = 1'b1;
         next_rd_addr = s_axi_araddr & ADDR_ALIGN;
      end
      if (rd_pend) begin
         next_rd_pend = 1'b0;
         next_rvalid = 1'b1;
         next_rdata = rd_err ? RST_REG : rd_data;
         next_rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      next_awready = !next_aw_got && !next_bvalid;
      next_wready = !next_w_got && !next_bvalid;
      next_arready = !next_rd_pend && !next_rvalid;
   end

   // registers of the slave
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         wr <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         rd_pend <= 1'b0;
         rd_addr <= 8'h00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= RST_REG;
         s_axi_rresp <= RESP_OKAY;
      end else if (ce) begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         wr <= next_wr;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         rd_pend <= next_rd_pend;
         rd_addr <= next_rd_addr;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end
endmodule : cbt_axil_slave

//--- core/cbt_top.sv
// receive fresh-data flags and transmit request bookkeeping with tx scan
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cbt_top import cbt_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_store_valid,
   input wire logic [4:0] rx_store_index,
   input wire logic tx_done,
   input wire logic tx_ok,
   output logic tx_start,
   output logic [4:0] tx_start_index,
   output logic irq
);
   logic wr_go;
   cbt_wr_t wr;
   logic wr_err, rd_err;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic [31:0] wmask;

   // software visible state
   logic [NBUF-1:0] rx_buffer_fresh_flags, next_fresh;
   logic [NBUF-1:0] tx_request_pending, next_pending;
   logic [NBUF-1:0] tx_buffer_config_reg, next_cfg;
   logic [NBUF-1:0] tx_cancel_request_reg, next_cancel;
   logic [NBUF-1:0] tx_occurred_reg, next_occ;
   logic [NBUF-1:0] tx_cancel_finished_reg, next_cfin;
   logic [IRQW-1:0] irq_status, next_ist;
   logic [IRQW-1:0] irq_mask, next_imsk;
   logic next_irq;

   // scan and transmission state
   cbt_scan_t scan_st, next_scan_st;
   logic [5:0] scan_cnt, next_scan_cnt;
   logic [NBUF-1:0] cand, next_cand;
   logic cmp_valid, next_cmp_valid;
   logic [4:0] cmp_idx, next_cmp_idx;
   logic best_valid, next_best_valid;
   logic [4:0] best_idx, next_best_idx;
   logic [IDW-1:0] best_id, next_best_id;
   logic active, next_active;
   logic [4:0] active_idx, next_active_idx;
   logic next_tx_start;
   logic [4:0] next_tx_start_index;
   logic [IDW-1:0] id_rdata;

   // decoded write strobes and per-buffer event masks
   logic wr_cfg, wr_fresh, wr_add, wr_cancel, wr_occ, wr_cfin;
   logic wr_idwr, wr_ist, wr_imsk;
   logic [NBUF-1:0] rx_set, add_set, cancel_set, drop, done_clr;
   logic [NBUF-1:0] occ_set, cfin_set, active_mask;

   cbt_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_go(wr_go),
      .wr(wr),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   cbt_id_mem u_ids (
      .aclk(aclk),
      .ce(ce),
      .we(wr_idwr),
      .waddr(wr.data[IDWR_IDX_LSB +: 5]),
      .wdata(wr.data[IDWR_ID_LSB +: IDW]),
      .raddr(scan_cnt[4:0]),
      .rdata(id_rdata)
   );

   // address decode of the write side; pending register ignores writes but answers okay
   assign wmask = cbt_strb_mask(wr.strb);
   assign wr_cfg = wr_go && wr.addr == OFS_CFG;
   assign wr_fresh = wr_go && wr.addr == OFS_FRESH;
   assign wr_add = wr_go && wr.addr == OFS_ADD;
   assign wr_cancel = wr_go && wr.addr == OFS_CANCEL;
   assign wr_occ = wr_go && wr.addr == OFS_OCC;
   assign wr_cfin = wr_go && wr.addr == OFS_CFIN;
   assign wr_idwr = wr_go && wr.addr == OFS_IDWR && wr.strb == 4'hF;
   assign wr_ist = wr_go && wr.addr == OFS_IST;
   assign wr_imsk = wr_go && wr.addr == OFS_IMSK;
   assign wr_err = !(wr_cfg || wr_fresh || wr_add || wr_cancel || wr_occ || wr_cfin
                     || wr.addr == OFS_IDWR || wr_ist || wr_imsk || wr.addr == OFS_PEND);

   // read multiplexer
   always_comb begin
      rd_err = 1'b0;
      unique case (rd_addr)
         OFS_CFG: rd_data = tx_buffer_config_reg;
         OFS_FRESH: rd_data = rx_buffer_fresh_flags;
         OFS_PEND: rd_data = tx_request_pending;
         OFS_ADD: rd_data = RST_REG;
         OFS_CANCEL: rd_data = tx_cancel_request_reg;
         OFS_OCC: rd_data = tx_occurred_reg;
         OFS_CFIN: rd_data = tx_cancel_finished_reg;
         OFS_IDWR: rd_data = RST_REG;
         OFS_IST: rd_data = {29'h0000_0000, irq_status};
         OFS_IMSK: rd_data = {29'h0000_0000, irq_mask};
         default: begin
            rd_data = RST_REG;
            rd_err = 1'b1;
         end
      endcase
   end

   // per-buffer events of this cycle
   assign rx_set = rx_store_valid ? cbt_onehot(rx_store_index) : '0;
   assign add_set = wr_add ? (wr.data & wmask & tx_buffer_config_reg) : '0;
   assign cancel_set = wr_cancel ? (wr.data & wmask & tx_request_pending) : '0;
   assign active_mask = active ? cbt_onehot(active_idx) : '0;
   // cancelled requests not on the bus drop at once, scan or not
   assign drop = (tx_cancel_request_reg | cancel_set) & tx_request_pending
                 & ~active_mask;
   // ongoing frame ends: success, or a cancel waiting for its end
   assign done_clr = (active && tx_done
                      && (tx_ok || tx_cancel_request_reg[active_idx]))
                     ? active_mask : '0;
   assign occ_set = (active && tx_done && tx_ok) ? active_mask : '0;
   assign cfin_set = drop | (occ_set & tx_cancel_request_reg);

   // register state next values
   always_comb begin
      next_cfg = tx_buffer_config_reg;
      next_imsk = irq_mask;
      if (wr_cfg) begin
         next_cfg = (tx_buffer_config_reg & ~wmask) | (wr.data & wmask);
      end
      if (wr_imsk) begin
         next_imsk = wr.data[IRQW-1:0];
      end
      // write-one clear first, hardware set last so it wins
      next_fresh = rx_buffer_fresh_flags;
      if (wr_fresh) begin
         next_fresh = next_fresh & ~(wr.data & wmask);
      end
      next_fresh = next_fresh | rx_set;
      next_pending = (tx_request_pending & ~drop & ~done_clr) | add_set;
      next_cancel = (tx_cancel_request_reg & tx_request_pending) | cancel_set;
      next_occ = (tx_occurred_reg & ~add_set) | occ_set;
      next_cfin = (tx_cancel_finished_reg & ~add_set) | cfin_set;
      next_ist = irq_status;
      if (wr_ist) begin
         next_ist = irq_status & ~wr.data[IRQW-1:0];
      end
      next_ist[IRQ_RX] = next_ist[IRQ_RX] | (|rx_set);
      next_ist[IRQ_OCC] = next_ist[IRQ_OCC] | (|occ_set);
      next_ist[IRQ_CFIN] = next_ist[IRQ_CFIN] | (|cfin_set);
      next_irq = |(next_ist & next_imsk);
   end

   // register state flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_buffer_fresh_flags <= RST_REG;
         tx_request_pending <= RST_REG;
         tx_buffer_config_reg <= RST_REG;
         tx_cancel_request_reg <= RST_REG;
         tx_occurred_reg <= RST_REG;
         tx_cancel_finished_reg <= RST_REG;
         irq_status <= RST_IRQ;
         irq_mask <= RST_IRQ;
         irq <= 1'b0;
      end else if (ce) begin
         rx_buffer_fresh_flags <= next_fresh;
         tx_request_pending <= next_pending;
         tx_buffer_config_reg <= next_cfg;
         tx_cancel_request_reg <= next_cancel;
         tx_occurred_reg <= next_occ;
         tx_cancel_finished_reg <= next_cfin;
         irq_status <= next_ist;
         irq_mask <= next_imsk;
         irq <= next_irq;
      end
   end

   // tx scan: walks the snapshot of pending bits, keeps the lowest identifier
   always_comb begin
      next_scan_st = scan_st;
      next_scan_cnt = scan_cnt;
      next_cand = cand & ~drop;
      next_cmp_valid = 1'b0;
      next_cmp_idx = scan_cnt[4:0];
      next_best_valid = best_valid;
      next_best_idx = best_idx;
      next_best_id = best_id;
      next_active = active;
      next_active_idx = active_idx;
      next_tx_start = 1'b0;
      next_tx_start_index = tx_start_index;
      if (active && tx_done) begin
         next_active = 1'b0;
      end
      unique case (scan_st)
         SC_IDLE: begin
            // with no frame on the bus, any pending request not being dropped starts a scan
            if (!active && |(tx_request_pending & ~drop)) begin
               next_scan_st = SC_RUN;
               next_cand = tx_request_pending & ~drop;
               next_scan_cnt = 6'h00;
               next_best_valid = 1'b0;
            end
         end
         SC_RUN: begin
            // memory answers one cycle after the index was issued
            if (cmp_valid && cand[cmp_idx]
                && (!best_valid || id_rdata < best_id)) begin
               next_best_valid = 1'b1;
               next_best_idx = cmp_idx;
               next_best_id = id_rdata;
            end
            if (scan_cnt == SCAN_LAST) begin
               next_scan_st = SC_PICK;
            end else begin
               next_cmp_valid = 1'b1;
               next_scan_cnt = scan_cnt + 6'h01;
            end
         end
         SC_PICK: begin
            // the winner may have been cancelled meanwhile
            next_scan_st = SC_IDLE;
            if (best_valid && cand[best_idx] && !drop[best_idx]) begin
               next_tx_start = 1'b1;
               next_tx_start_index = best_idx;
               next_active = 1'b1;
               next_active_idx = best_idx;
            end
         end
      endcase
   end

   // scan and transmission flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_st <= SC_IDLE;
         scan_cnt <= 6'h00;
         cand <= RST_REG;
         cmp_valid <= 1'b0;
         cmp_idx <= 5'h00;
         best_valid <= 1'b0;
         best_idx <= 5'h00;
         best_id <= '0;
         active <= 1'b0;
         active_idx <= 5'h00;
         tx_start <= 1'b0;
         tx_start_index <= 5'h00;
      end else if (ce) begin
         scan_st <= next_scan_st;
         scan_cnt <= next_scan_cnt;
         cand <= next_cand;
         cmp_valid <= next_cmp_valid;
         cmp_idx <= next_cmp_idx;
         best_valid <= next_best_valid;
         best_idx <= next_best_idx;
         best_id <= next_best_id;
         active <= next_active;
         active_idx <= next_active_idx;
         tx_start <= next_tx_start;
         tx_start_index <= next_tx_start_index;
      end
   end
endmodule : cbt_top

//--- bench/cbt_assertions.sv
// port-level checks on the buffer flag tracking block
`timescale 1ns/1ps
module cbt_assertions import cbt_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic tx_start,
   input wire logic [4:0] tx_start_index,
   input wire logic tx_done
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic busy;
   logic next_busy;
   // a started frame stays outstanding until the engine reports its end
   always_comb next_busy = tx_start ? 1'b1 : (tx_done ? 1'b0 : busy);
   always_ff @(posedge aclk) busy <= aresetn ? next_busy : 1'b0;
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> ##1 s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   property p_b_refuse;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_b_refuse: assert property (p_b_refuse) else $error("write taken while answer pending");
   property p_r_refuse;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_r_refuse: assert property (p_r_refuse) else $error("read taken while answer pending");
   property p_err_zero;
      s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read data not zero");
   property p_start_pulse;
      tx_start |=> !tx_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
   property p_one_frame;
      tx_start |-> !busy;
   endproperty
   a_one_frame: assert property (p_one_frame) else $error("start while frame outstanding");
   property p_idx_hold;
      $changed(tx_start_index) |-> tx_start;
   endproperty
   a_idx_hold: assert property (p_idx_hold) else $error("start index moved");
endmodule : cbt_assertions

//--- bench/cbt_engine_model.sv
// protocol engine stand-in: receive stores and frame completion
`timescale 1ns/1ps
module cbt_engine_model (
   input wire logic aclk,
   input wire logic tx_start,
   input wire logic rx_go,
   input wire logic [4:0] rx_idx,
   input wire logic [7:0] dly,
   input wire logic ok_in,
   output logic rx_store_valid = 1'b0,
   output logic [4:0] rx_store_index = 5'h0,
   output logic tx_done = 1'b0,
   output logic tx_ok = 1'b0
);
   int cnt = -1;
   // one completion per start, dly+2 cycles after it; qualifiers scrambled when idle
   always @(posedge aclk) begin
      rx_store_valid <= rx_go;
      rx_store_index <= rx_go ? rx_idx : ~rx_store_index;
      tx_done <= 1'b0;
      tx_ok <= ~tx_ok;
      if (tx_start) begin
         cnt <= dly;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if (cnt == 0) begin
         tx_done <= 1'b1;
         tx_ok <= ok_in;
         cnt <= -1;
      end
   end
endmodule : cbt_engine_model

//--- bench/test_can_buffer_flag_tracking.sv
// self-checking bench for the buffer flag tracking block
`timescale 1ns/1ps
module test_can_buffer_flag_tracking import cbt_pkg::*;;
   logic aclk = 1'b0, aresetn = 1'b0, rx_go = 1'b0, ok_in = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, dly = 8'h28;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [4:0] rx_idx = 5'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic rx_store_valid, tx_done, tx_ok, tx_start;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [4:0] rx_store_index, tx_start_index;
   logic [33:0] exq[$];
   logic [4:0] sq[$];
   int failures = 0, num_checks = 0, ndone = 0, seed = 32'h34E3EB06;
   // 200 MHz clock
   always #2.5 aclk = ~aclk;
   cbt_top u_cbt_top (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .rx_store_valid, .rx_store_index, .tx_done, .tx_ok, .tx_start, .tx_start_index, .irq);
   cbt_engine_model u_cbt_engine_model (.aclk, .tx_start, .rx_go, .rx_idx, .dly, .ok_in,
      .rx_store_valid, .rx_store_index, .tx_done, .tx_ok);
   task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   // one clock with a bound on every wait
   task automatic step(inout int n);
      @(posedge aclk);
      n++;
      if (n > 600) begin
         failures++;
         summarize();
      end
   endtask : step
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      logic aw_ok, w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // each channel is released at the edge that takes it
      while (!(aw_ok && w_ok)) begin
         step(n);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do step(n); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {32'h0, s_axi_bresp}, {32'h0, r});
      // let an edge pass so the next call does not re-raise bready in this step
      step(n);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      n = 0;
      exq.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do step(n); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do step(n); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      // let an edge pass so the next call does not re-raise rready in this step
      step(n);
   endtask : rd
   task automatic rx(input logic [4:0] i);
      int n;
      n = 0;
      rx_go <= 1'b1;
      rx_idx <= i;
      step(n);
      rx_go <= 1'b0;
      repeat (4) step(n);
   endtask : rx
   // read words against the oldest note; starts and completions recorded
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, exq.pop_front());
      if (tx_start) sq.push_back(tx_start_index);
      if (tx_done) ndone++;
   end
   initial begin
      logic [4:0] ri;
      logic [10:0] id;
      int n;
      n = 0;
      ri = 5'($random(seed));
      id = 11'($random(seed)) | 11'h400;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_FRESH, 34'h0);
      rd(OFS_PEND, 34'h0);
      wr(OFS_IMSK, 32'h1, RESP_OKAY);
      rx(ri);
      rd(OFS_FRESH, {2'h0, 32'h1 << ri});
      chk("irq", {33'h0, irq}, 34'h1);
      wr(OFS_FRESH, ~(32'h1 << ri), RESP_OKAY);
      rd(OFS_FRESH, {2'h0, 32'h1 << ri});
      wr(OFS_FRESH, 32'h1 << ri, RESP_OKAY);
      rd(OFS_FRESH, 34'h0);
      // store and write-one clear land on the same edge: the store wins
      fork
         wr(OFS_FRESH, 32'h1 << ri, RESP_OKAY);
         rx(ri);
      join
      rd(OFS_FRESH, {2'h0, 32'h1 << ri});
      wr(OFS_IST, 32'h1, RESP_OKAY);
      repeat (2) step(n);
      chk("irq", {33'h0, irq}, 34'h0);
      wr(OFS_IMSK, 32'h0, RESP_OKAY);
      rx(ri);
      chk("irq", {33'h0, irq}, 34'h0);
      wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
      rd(8'h10, {RESP_SLVERR, 32'h0});
      wr(OFS_PEND, 32'hFFFF_FFFF, RESP_OKAY);
      rd(OFS_PEND, 34'h0);
      // buffers 0..7 enabled; buffer 5 gets the lower identifier of 3 and 5
      wr(OFS_CFG, 32'h0000_00FF, RESP_OKAY);
      wr(OFS_IDWR, {11'h0, 5'h3, 5'h0, id}, RESP_OKAY);
      wr(OFS_IDWR, {11'h0, 5'h5, 5'h0, id ^ 11'h400}, RESP_OKAY);
      wr(OFS_IDWR, {11'h0, 5'h1, 5'h0, 11'h0}, RESP_OKAY);
      wr(OFS_ADD, 32'h0000_0228, RESP_OKAY);
      wr(OFS_ADD, 32'h0000_0002, RESP_OKAY);
      rd(OFS_PEND, 34'h2A);
      wr(OFS_CANCEL, 32'h2, RESP_OKAY);
      rd(OFS_PEND, 34'h28);
      rd(OFS_CANCEL, 34'h0);
      while (sq.size() == 0) step(n);
      chk("index", {29'h0, sq.pop_front()}, 34'h5);
      wr(OFS_CANCEL, 32'h20, RESP_OKAY);
      rd(OFS_PEND, 34'h28);
      while (ndone < 1) step(n);
      repeat (2) step(n);
      rd(OFS_PEND, 34'h08);
      rd(OFS_CANCEL, 34'h0);
      rd(OFS_OCC, 34'h20);
      rd(OFS_CFIN, 34'h22);
      while (sq.size() == 0) step(n);
      chk("index", {29'h0, sq.pop_front()}, 34'h3);
      while (ndone < 2) step(n);
      repeat (2) step(n);
      rd(OFS_PEND, 34'h0);
      rd(OFS_OCC, 34'h28);
      summarize();
   end
endmodule : test_can_buffer_flag_tracking
bind cbt_top cbt_assertions u_cbt_assertions (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rdata, .s_axi_rresp, .tx_start, .tx_start_index, .tx_done);
